/* File: core/qpst_defs.svh */
// Address map, bit positions and reset values of the status and terminal control block
`ifndef QPST_DEFS_SVH
`define QPST_DEFS_SVH

// Serial register addresses
`define QPST_A_VW0    4'h0
`define QPST_A_VW1    4'h1
`define QPST_A_NW0    4'h2
`define QPST_A_NW1    4'h3
`define QPST_A_TC_LO  4'h4
`define QPST_A_STAT   4'h5
`define QPST_A_VW2    4'h6
`define QPST_A_VW3    4'h7
`define QPST_A_NW2    4'h8
`define QPST_A_NW3    4'h9
`define QPST_A_TC_HI  4'ha
`define QPST_A_GP_LO  4'hb
`define QPST_A_GP_HI  4'hf

// Status word bit positions
`define QPST_ST_TOP   8
`define QPST_ST_B7    7
`define QPST_ST_L3    6
`define QPST_ST_L2    5
`define QPST_ST_BUSY  4
`define QPST_ST_L1    3
`define QPST_ST_L0    2
`define QPST_ST_B1    1
`define QPST_ST_WP    0

// Terminal control layout
`define QPST_TC_TOP   8
`define QPST_TC_RST   9'h1ff
`define QPST_NIB_SD   3
`define QPST_NIB_A    2
`define QPST_NIB_W    1
`define QPST_NIB_B    0

`endif

/* File: core/qpst_pkg.sv */
// Types shared by the status and terminal control block
package qpst_pkg;

    typedef enum logic [1:0] {
        QPST_OP_WR  = 2'h0,
        QPST_OP_INC = 2'h1,
        QPST_OP_DEC = 2'h2,
        QPST_OP_RD  = 2'h3
    } qpst_op_t;

    typedef struct packed {
        logic [3:0] addr;
        qpst_op_t   op;
        logic [8:0] data;
    } qpst_cmd_t;

    typedef struct packed {
        logic [8:0] rd_data;
        logic       accepted;
        logic       error;
    } qpst_rsp_t;

    typedef enum logic [0:0] {
        QPST_L_IDLE = 1'b0,
        QPST_L_WAIT = 1'b1
    } qpst_lstate_t;

    typedef struct packed {
        logic [1:0] req_sync;
        logic       req_seen;
        logic       ack_tgl;
        qpst_rsp_t  rsp;
        logic [8:0] tc_lo;
        logic [8:0] tc_hi;
        logic [3:0] lock;
        logic       wp_bit;
        logic       load_pend;
        logic [1:0] rpin_sync;
        logic [1:0] wp_sync;
        logic [1:0] hvc_sync;
        logic       wp_out;
        logic       err;
        logic [3:0] vw_we;
        logic       nv_we;
        qpst_cmd_t  fwd;
    } qpst_core_t;

    typedef struct packed {
        qpst_lstate_t st;
        logic         req_tgl;
        logic [1:0]   ack_sync;
        qpst_cmd_t    cmd;
        logic         rsp_vld;
        qpst_rsp_t    rsp;
    } qpst_link_t;

endpackage

/* File: core/qpst_regs.sv */
// Status and terminal control registers of a quad digital potentiometer
`timescale 1ns/1ps
`default_nettype none
`include "qpst_defs.svh"

// Operation
// R1: Status bits 8, 7 and 1 always read as one.
// R2: Lock of network 3 rejects its wiper writes and its high control nibble.
// R3: Lock of network 2 rejects its wiper writes and its low control nibble.
// R4: Lock of network 1 rejects its wiper writes and its high control nibble.
// R5: Lock of network 0 rejects its wiper writes and its low control nibble.
// R6: Lock bits mirror stored values and reload after any reset event.
// R7: Ordinary writes never alter lock or protect status bits.
// R8: Busy flag follows the write cycle; only four volatile addresses served then.
// R9: Write protect blocks every nonvolatile write, wipers and general words.
// R10: Write protect never blocks volatile wiper or terminal control changes.
// R11: Protect status is pin asserted OR stored protect bit.
// R12: Each control register holds two nibbles, odd network high, even low.
// R13: Low register bits 6..4 link network 1 terminal A, wiper, terminal B.
// R14: Low register bits 2..0 link network 0 terminal A, wiper, terminal B.
// R15: Clearing bit 7 or 3 forces shutdown of that network; one releases.
// R16: Control bit 8 reads one and cannot be written.
// R17: Control values reach the terminals only after the command completes.
// R18: Power-on reset loads both control registers with all ones.
// R19: Host rewrites control registers after detecting a power-on reset.
// R20: Control changes never touch stored wiper values.
// R21: Status register answers reads at address 05h.
// R22: Nonvolatile access during a write cycle is an error condition.
// R23: High register uses the same layout for networks 3 and 2.
// R24: Writes to the status register are ignored.
module qpst_regs (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic                reset_pin_n,
    input  wire logic                wp_pin_n,
    input  wire logic                hvc_pin,
    input  wire logic [3:0]          nv_lock,
    input  wire logic                nv_wp,
    input  wire logic                nv_cfg_done,
    input  wire logic                nv_busy,
    input  wire logic [8:0]          ext_rd_data,
    output logic                     nv_write_protect,
    output logic                     cmd_error,
    output logic [3:0]               vol_wiper_we,
    output logic                     nv_write_req,
    output qpst_pkg::qpst_cmd_t      fwd_cmd,
    output logic [3:0]               net_force_shutdown_n,
    output logic [3:0]               term_a_link,
    output logic [3:0]               wiper_link,
    output logic [3:0]               term_b_link,
    input  wire logic                link_clk,
    input  wire logic                cmd_end,
    input  wire logic [3:0]          cmd_addr,
    input  wire qpst_pkg::qpst_op_t  cmd_op,
    input  wire logic [8:0]          cmd_data,
    output logic                     cmd_ready,
    output logic                     rsp_valid,
    output qpst_pkg::qpst_rsp_t      rsp
);

    qpst_pkg::qpst_core_t core_reg;
    qpst_pkg::qpst_core_t core_next;
    qpst_pkg::qpst_link_t link_reg;
    qpst_pkg::qpst_link_t link_next;
    logic [15:0]          tc_bits;

    ////////////////////////////////////////////////////////////////////////
    // Core domain

    always_comb begin
        logic [3:0]         a;
        qpst_pkg::qpst_op_t op;
        logic               is_vw;
        logic               is_nw;
        logic               is_gp;
        logic               busy_ok;
        logic [1:0]         idx;
        logic               acc;
        logic               er;
        logic [8:0]         rd;
        logic [8:0]         st;
        logic [7:0]         msk;
        logic [8:0]         old_tc;
        a       = link_reg.cmd.addr;
        op      = link_reg.cmd.op;
        is_vw   = 1'b0;
        is_nw   = 1'b0;
        is_gp   = 1'b0;
        busy_ok = 1'b0;
        idx     = 2'h0;
        acc     = 1'b0;
        er      = 1'b0;
        rd      = 9'h000;
        st      = 9'h000;
        msk     = 8'h00;
        old_tc  = 9'h000;
        core_next          = core_reg;
        core_next.vw_we    = 4'h0;
        core_next.nv_we    = 1'b0;
        core_next.req_sync = {core_reg.req_sync[0], link_reg.req_tgl};
        core_next.rpin_sync = {core_reg.rpin_sync[0], reset_pin_n};
        core_next.wp_sync  = {core_reg.wp_sync[0], wp_pin_n};
        core_next.hvc_sync = {core_reg.hvc_sync[0], hvc_pin};

        // Lock and protect state only ever comes from storage
        if (core_reg.load_pend || nv_cfg_done) begin // [R6] [R7]
            core_next.lock      = nv_lock;
            core_next.wp_bit    = nv_wp;
            core_next.load_pend = 1'b0;
        end
        if (!core_reg.rpin_sync[1]) begin // [R6]
            core_next.load_pend = 1'b1;
        end
        core_next.wp_out = ~core_reg.wp_sync[1] | core_reg.wp_bit; // [R11]

        // Status word as read back
        st[`QPST_ST_TOP]  = 1'b1; // [R1]
        st[`QPST_ST_B7]   = 1'b1; // [R1]
        st[`QPST_ST_L3]   = core_reg.lock[3];
        st[`QPST_ST_L2]   = core_reg.lock[2];
        st[`QPST_ST_BUSY] = nv_busy; // [R8]
        st[`QPST_ST_L1]   = core_reg.lock[1];
        st[`QPST_ST_L0]   = core_reg.lock[0];
        st[`QPST_ST_B1]   = 1'b1; // [R1]
        st[`QPST_ST_WP]   = core_reg.wp_out;

        // Address classes
        is_vw = (a == `QPST_A_VW0) || (a == `QPST_A_VW1) ||
                (a == `QPST_A_VW2) || (a == `QPST_A_VW3);
        is_nw = (a == `QPST_A_NW0) || (a == `QPST_A_NW1) ||
                (a == `QPST_A_NW2) || (a == `QPST_A_NW3);
        is_gp = (a >= `QPST_A_GP_LO) && (a <= `QPST_A_GP_HI);
        busy_ok = (a == `QPST_A_VW0) || (a == `QPST_A_VW1) ||
                  (a == `QPST_A_TC_LO) || (a == `QPST_A_STAT);
        if ((a == `QPST_A_VW1) || (a == `QPST_A_NW1)) begin
            idx = 2'h1;
        end else if ((a == `QPST_A_VW2) || (a == `QPST_A_NW2)) begin
            idx = 2'h2;
        end else if ((a == `QPST_A_VW3) || (a == `QPST_A_NW3)) begin
            idx = 2'h3;
        end

        // A control register is chosen with its own pair of locks
        if (a == `QPST_A_TC_HI) begin
            old_tc = core_reg.tc_hi;
            msk    = {{4{core_reg.lock[3]}}, {4{core_reg.lock[2]}}}; // [R2] [R3] [R23]
        end else begin
            old_tc = core_reg.tc_lo;
            msk    = {{4{core_reg.lock[1]}}, {4{core_reg.lock[0]}}}; // [R4] [R5]
        end

        if (core_reg.req_sync[1] != core_reg.req_seen) begin
            core_next.req_seen = core_reg.req_sync[1];
            core_next.ack_tgl  = ~core_reg.ack_tgl;
            if (nv_busy && !busy_ok) begin // [R8]
                er = is_nw || is_gp; // [R22]
            end else if (op == qpst_pkg::QPST_OP_RD) begin
                acc = 1'b1;
                if (a == `QPST_A_STAT) begin // [R21]
                    rd = st;
                end else if (a == `QPST_A_TC_LO) begin
                    rd = core_reg.tc_lo;
                end else if (a == `QPST_A_TC_HI) begin
                    rd = core_reg.tc_hi;
                end else begin
                    rd = ext_rd_data;
                end
            end else if (a == `QPST_A_STAT) begin
                // Status is read only; the write is dropped
                er = 1'b1; // [R24] [R7]
            end else if ((a == `QPST_A_TC_LO) || (a == `QPST_A_TC_HI)) begin
                if (op != qpst_pkg::QPST_OP_WR) begin
                    er = 1'b1;
                end else begin
                    // Protect has no say here; only the network locks mask
                    acc = ~&msk; // [R10]
                    old_tc[7:0] = (cmd_data_hold(link_reg.cmd.data) & ~msk) |
                                  (old_tc[7:0] & msk); // [R12]
                    old_tc[`QPST_TC_TOP] = 1'b1; // [R16]
                    if (a == `QPST_A_TC_HI) begin
                        core_next.tc_hi = old_tc; // [R20]
                    end else begin
                        core_next.tc_lo = old_tc; // [R20]
                    end
                end
            end else if (is_vw) begin
                if (!core_reg.lock[idx]) begin // [R2] [R3] [R4] [R5] [R10]
                    acc                  = 1'b1;
                    core_next.vw_we[idx] = 1'b1;
                    core_next.fwd        = link_reg.cmd;
                end
            end else if (is_nw || is_gp) begin
                if (op != qpst_pkg::QPST_OP_WR) begin
                    er = 1'b1;
                end else if (!core_reg.wp_out &&
                             !(is_nw && core_reg.lock[idx])) begin // [R9] [R2] [R3] [R4] [R5]
                    acc             = 1'b1;
                    core_next.nv_we = 1'b1;
                    core_next.fwd   = link_reg.cmd;
                end
            end
            core_next.rsp = '{rd_data: rd, accepted: acc, error: er};
        end

        // Leaving the error state needs the high-voltage pin seen high;
        // a new error in the same cycle wins
        if (core_reg.hvc_sync[1]) begin
            core_next.err = 1'b0;
        end
        if (er) begin
            core_next.err = 1'b1; // [R22]
        end
    end

    // Bits above 7 of the payload are never written into a control nibble
    function automatic logic [7:0] cmd_data_hold(input logic [8:0] d);
        cmd_data_hold = d[7:0];
    endfunction

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_reg           <= '0;
            core_reg.tc_lo     <= `QPST_TC_RST; // [R18]
            core_reg.tc_hi     <= `QPST_TC_RST; // [R18]
            // Locked and protected until storage has been read back
            core_reg.lock      <= 4'hf;
            core_reg.wp_bit    <= 1'b1;
            core_reg.wp_out    <= 1'b1;
            core_reg.load_pend <= 1'b1; // [R6]
            core_reg.rpin_sync <= 2'h3;
            core_reg.wp_sync   <= 2'h3;
        end else if (ce) begin
            core_reg <= core_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain

    // The request is only raised at the end of a serial command, so control
    // values never change while the command is still in flight
    always_comb begin
        link_next          = link_reg;
        link_next.rsp_vld  = 1'b0;
        link_next.ack_sync = {link_reg.ack_sync[0], core_reg.ack_tgl};
        unique case (link_reg.st)
            qpst_pkg::QPST_L_IDLE: begin
                if (cmd_end) begin // [R17]
                    link_next.cmd     = '{addr: cmd_addr, op: cmd_op, data: cmd_data};
                    link_next.req_tgl = ~link_reg.req_tgl;
                    link_next.st      = qpst_pkg::QPST_L_WAIT;
                end
            end
            qpst_pkg::QPST_L_WAIT: begin
                // Response is stable once the toggle has crossed
                if (link_reg.ack_sync[1] == link_reg.req_tgl) begin
                    link_next.rsp     = core_reg.rsp;
                    link_next.rsp_vld = 1'b1;
                    link_next.st      = qpst_pkg::QPST_L_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign tc_bits = {core_reg.tc_hi[7:0], core_reg.tc_lo[7:0]};

    genvar n;
    generate
        for (n = 0; n < 4; n = n + 1) begin : g_net
            assign net_force_shutdown_n[n] = tc_bits[4*n + `QPST_NIB_SD]; // [R15]
            assign term_a_link[n] = tc_bits[4*n + `QPST_NIB_A]; // [R13] [R14] [R23]
            assign wiper_link[n]  = tc_bits[4*n + `QPST_NIB_W]; // [R13] [R14] [R23]
            assign term_b_link[n] = tc_bits[4*n + `QPST_NIB_B]; // [R13] [R14] [R23]
        end
    endgenerate

    assign nv_write_protect = core_reg.wp_out;
    assign cmd_error        = core_reg.err;
    assign vol_wiper_we     = core_reg.vw_we;
    assign nv_write_req     = core_reg.nv_we;
    assign fwd_cmd          = core_reg.fwd;
    assign cmd_ready        = (link_reg.st == qpst_pkg::QPST_L_IDLE);
    assign rsp_valid        = link_reg.rsp_vld;
    assign rsp              = link_reg.rsp;

endmodule
`default_nettype wire

/* File: testbench/qpst_regs_properties.sv */
// Port-level checks of the status and terminal control block
`timescale 1ns/1ps
`default_nettype none
`include "qpst_defs.svh"
module qpst_regs_chk (
    input wire logic                ref_clk,
    input wire logic                rst_n,
    input wire logic                ce,
    input wire logic                wp_pin_n,
    input wire logic                nv_busy,
    input wire logic                nv_write_protect,
    input wire logic                nv_write_req,
    input wire logic [3:0]          vol_wiper_we,
    input wire logic [3:0]          net_force_shutdown_n,
    input wire logic [3:0]          term_a_link,
    input wire logic [3:0]          wiper_link,
    input wire logic [3:0]          term_b_link,
    input wire logic                link_clk,
    input wire logic                cmd_end,
    input wire logic [3:0]          cmd_addr,
    input wire qpst_pkg::qpst_op_t  cmd_op,
    input wire logic                cmd_ready,
    input wire logic                rsp_valid,
    input wire qpst_pkg::qpst_rsp_t rsp
);
    logic [3:0]         la;
    qpst_pkg::qpst_op_t lo;
    logic               take;
    logic               rd_now;
    assign take = cmd_end && cmd_ready;
    assign rd_now = rsp_valid && lo == qpst_pkg::QPST_OP_RD;
    ////////////////////////////////////////////////////////////////////////////////
    // The answer arrives cycles later, so the taken command is remembered
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            la <= 4'h0;
            lo <= qpst_pkg::QPST_OP_WR;
        end else if (take) begin
            la <= cmd_addr;
            lo <= cmd_op;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_stat_fixed: assert property (@(posedge link_clk) disable iff (!rst_n)
        rd_now && la == `QPST_A_STAT |-> rsp.rd_data[8:7] == 2'b11 && rsp.rd_data[1])
        else $error("status reserved bits not one");
    a_stat_ro: assert property (@(posedge link_clk) disable iff (!rst_n)
        rsp_valid && la == `QPST_A_STAT && lo != qpst_pkg::QPST_OP_RD |-> !rsp.accepted)
        else $error("status write was accepted");
    a_tc_top: assert property (@(posedge link_clk) disable iff (!rst_n)
        rd_now && (la == `QPST_A_TC_LO || la == `QPST_A_TC_HI) |-> rsp.rd_data[8])
        else $error("control top bit not one");
    a_ready_low: assert property (@(posedge link_clk) disable iff (!rst_n)
        take |=> !cmd_ready [*2])
        else $error("link ready during command");
    a_rsp_bound: assert property (@(posedge link_clk) disable iff (!rst_n)
        take |-> ##[2:9] rsp_valid)
        else $error("no answer to command");
    a_wp_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!wp_pin_n && ce) [*4] |-> nv_write_protect)
        else $error("protect pin not reflected");
    a_wp_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        nv_write_protect && $past(nv_write_protect) |-> !nv_write_req)
        else $error("stored write while protected");
    a_busy_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        nv_busy && $past(nv_busy) |-> !nv_write_req)
        else $error("stored write while busy");
    a_term_late: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed({net_force_shutdown_n, term_a_link, wiper_link, term_b_link}) |-> !cmd_ready)
        else $error("terminals changed outside a command");
    c_stat_read: cover property (@(posedge link_clk) rd_now && la == `QPST_A_STAT);
    c_nv_write: cover property (@(posedge ref_clk) nv_write_req);
    c_vol_write: cover property (@(posedge ref_clk) |vol_wiper_we);
endmodule
bind qpst_regs qpst_regs_chk i_chk (.ref_clk, .rst_n, .ce, .wp_pin_n, .nv_busy,
    .nv_write_protect, .nv_write_req, .vol_wiper_we, .net_force_shutdown_n, .term_a_link,
    .wiper_link, .term_b_link, .link_clk, .cmd_end, .cmd_addr, .cmd_op, .cmd_ready,
    .rsp_valid, .rsp);
`default_nettype wire

/* File: testbench/qpst_host.sv */
// Host model issuing serial commands on the link
`timescale 1ns/1ps
`default_nettype none
module qpst_host (
    output logic                    link_clk,
    output logic                    cmd_end,
    output logic [3:0]              cmd_addr,
    output qpst_pkg::qpst_op_t      cmd_op,
    output logic [8:0]              cmd_data,
    input  wire logic               cmd_ready,
    input  wire logic               rsp_valid,
    input  wire qpst_pkg::qpst_rsp_t rsp
);
    logic run;
    // Link clock only runs while a command is in flight
    initial begin
        link_clk = 1'b0;
        run = 1'b0;
        cmd_end = 1'b0;
        cmd_addr = 4'h0;
        cmd_op = qpst_pkg::QPST_OP_RD;
        cmd_data = 9'h000;
        #37;
        forever begin
            #80;
            if (run || link_clk) link_clk = ~link_clk;
        end
    end
    task automatic xfer(input logic [3:0] a, input qpst_pkg::qpst_op_t o,
                        input logic [8:0] d, output qpst_pkg::qpst_rsp_t r);
        int n;
        run = 1'b1;
        @(posedge link_clk);
        #1;
        cmd_end = 1'b1;
        cmd_addr = a;
        cmd_op = o;
        cmd_data = d;
        while (cmd_ready !== 1'b1) begin
            @(posedge link_clk);
            #1;
        end
        @(posedge link_clk);
        #1;
        // Released address and data lines show garbage, not the old value; the op line keeps its value
        cmd_end = 1'b0;
        cmd_addr = ~a;
        cmd_data = ~d;
        for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) begin
            @(posedge link_clk);
            #1;
        end
        // A missing answer shows as accepted and error at once, which no check expects
        if (rsp_valid === 1'b1) begin
            r = rsp;
        end else begin
            r = '1;
        end
        @(posedge link_clk);
        run = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/quad_pot_status_terminal_regs_test.sv */
// Testbench of the status and terminal control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module quad_pot_status_terminal_regs_test;
    localparam qpst_pkg::qpst_op_t WR = qpst_pkg::QPST_OP_WR;
    localparam qpst_pkg::qpst_op_t INC = qpst_pkg::QPST_OP_INC;
    localparam qpst_pkg::qpst_op_t DEC = qpst_pkg::QPST_OP_DEC;
    localparam qpst_pkg::qpst_op_t RD = qpst_pkg::QPST_OP_RD;
    logic ref_clk, rst_n, ce, reset_pin_n, wp_pin_n, hvc_pin, nv_wp, nv_cfg_done, nv_busy;
    logic [3:0] nv_lock, vol_wiper_we, net_force_shutdown_n, term_a_link, wiper_link;
    logic [3:0] term_b_link, cmd_addr, we_seen;
    logic [8:0] ext_rd_data, cmd_data;
    logic nv_write_protect, cmd_error, nv_write_req, link_clk, cmd_end, cmd_ready;
    logic rsp_valid, nv_seen, seen_clr;
    qpst_pkg::qpst_cmd_t fwd_cmd;
    qpst_pkg::qpst_op_t cmd_op;
    qpst_pkg::qpst_rsp_t rsp, r;
    int miscompares, tests_run;
    wire logic [15:0] term = {net_force_shutdown_n, term_a_link, wiper_link, term_b_link};
    qpst_regs i_qpst_regs (.ref_clk, .rst_n, .ce, .reset_pin_n, .wp_pin_n, .hvc_pin,
        .nv_lock, .nv_wp, .nv_cfg_done, .nv_busy, .ext_rd_data, .nv_write_protect,
        .cmd_error, .vol_wiper_we, .nv_write_req, .fwd_cmd, .net_force_shutdown_n,
        .term_a_link, .wiper_link, .term_b_link, .link_clk, .cmd_end, .cmd_addr,
        .cmd_op, .cmd_data, .cmd_ready, .rsp_valid, .rsp);
    qpst_host i_qpst_host (.link_clk, .cmd_end, .cmd_addr, .cmd_op, .cmd_data,
        .cmd_ready, .rsp_valid, .rsp);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Pulse monitors have this one driver; the tasks only ask for a clear
    always @(posedge ref_clk) begin
        if (!rst_n || seen_clr) begin
            we_seen <= 4'h0;
            nv_seen <= 1'b0;
        end else begin
            we_seen <= we_seen | vol_wiper_we;
            nv_seen <= nv_seen | nv_write_req;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic cmd(input logic [3:0] a, input qpst_pkg::qpst_op_t o,
                       input logic [8:0] d, input logic [1:0] ae);
        i_qpst_host.xfer(a, o, d, r);
        `CHK("accepted_error", ae, {r.accepted, r.error})
        // Back on a falling core edge, so pin changes that follow keep to it
        idle(1);
    endtask
    // Clears the sticky error through the high-voltage pin and the pulse monitors
    task automatic clr();
        idle(1);
        seen_clr = 1'b1;
        hvc_pin = 1'b1;
        idle(1);
        seen_clr = 1'b0;
        idle(5);
        hvc_pin = 1'b0;
        idle(6);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, reset_pin_n, wp_pin_n, hvc_pin, nv_wp, nv_cfg_done, nv_busy} = 7'h30;
        ce = 1'b1;
        nv_lock = 4'h9;
        ext_rd_data = 9'h0a5;
        seen_clr = 1'b0;
        miscompares = 0;
        tests_run = 0;
        idle(8);
        rst_n = 1'b1;
        `CHK("term_por", 16'hffff, term)
        idle(8);
        cmd(4'h5, RD, 9'h000, 2'b10);
        `CHK("status", 9'h1c6, r.rd_data)
        cmd(4'h5, WR, 9'h000, 2'b01);
        `CHK("error", 1'b1, cmd_error)
        cmd(4'h5, RD, 9'h000, 2'b10);
        `CHK("status_kept", 9'h1c6, r.rd_data)
        cmd(4'h4, INC, 9'h000, 2'b01);
        clr();
        `CHK("error_clr", 1'b0, cmd_error)
        cmd(4'h4, WR, 9'h000, 2'b10);
        `CHK("term_lo0", 16'hdddd, term)
        cmd(4'h4, WR, 9'h050, 2'b10);
        `CHK("term_lo1", 16'hdfdf, term)
        cmd(4'h4, RD, 9'h000, 2'b10);
        `CHK("tc_lo", 9'h15f, r.rd_data)
        cmd(4'ha, WR, 9'h03a, 2'b10);
        `CHK("term_hi", 16'hdbdb, term)
        cmd(4'ha, RD, 9'h000, 2'b10);
        `CHK("tc_hi", 9'h1fa, r.rd_data)
        `CHK("wiper_untouched", 4'h0, we_seen)
        cmd(4'h0, WR, 9'h040, 2'b00);
        cmd(4'h7, WR, 9'h040, 2'b00);
        cmd(4'h1, INC, 9'h000, 2'b10);
        cmd(4'h6, DEC, 9'h000, 2'b10);
        `CHK("wiper_we", 4'h6, we_seen)
        cmd(4'h1, RD, 9'h000, 2'b10);
        `CHK("wiper_rd", 9'h0a5, r.rd_data)
        wp_pin_n = 1'b0;
        idle(8);
        `CHK("wp_out", 1'b1, nv_write_protect)
        cmd(4'h5, RD, 9'h000, 2'b10);
        `CHK("status_wp", 9'h1c7, r.rd_data)
        cmd(4'h3, WR, 9'h080, 2'b00);
        cmd(4'hb, WR, 9'h001, 2'b00);
        cmd(4'h1, WR, 9'h010, 2'b10);
        cmd(4'h4, WR, 9'h0ff, 2'b10);
        `CHK("term_wp", 16'hfbfb, term)
        `CHK("nv_req_wp", 1'b0, nv_seen)
        wp_pin_n = 1'b1;
        idle(8);
        cmd(4'h3, WR, 9'h080, 2'b10);
        `CHK("nv_req", 1'b1, nv_seen)
        `CHK("fwd", {4'h3, WR, 9'h080}, fwd_cmd)
        nv_lock = 4'h2;
        nv_wp = 1'b1;
        nv_cfg_done = 1'b1;
        idle(1);
        nv_cfg_done = 1'b0;
        idle(8);
        cmd(4'h5, RD, 9'h000, 2'b10);
        `CHK("status_reload", 9'h18b, r.rd_data)
        cmd(4'h4, WR, 9'h000, 2'b10);
        `CHK("term_l1", 16'heaea, term)
        cmd(4'h1, WR, 9'h020, 2'b00);
        nv_lock = 4'h9;
        nv_wp = 1'b0;
        reset_pin_n = 1'b0;
        idle(4);
        reset_pin_n = 1'b1;
        idle(8);
        cmd(4'h5, RD, 9'h000, 2'b10);
        `CHK("status_pin", 9'h1c6, r.rd_data)
        `CHK("term_pin", 16'heaea, term)
        nv_busy = 1'b1;
        idle(2);
        cmd(4'h5, RD, 9'h000, 2'b10);
        `CHK("status_busy", 9'h1d6, r.rd_data)
        cmd(4'h3, WR, 9'h080, 2'b01);
        `CHK("error_busy", 1'b1, cmd_error)
        cmd(4'h1, WR, 9'h030, 2'b10);
        cmd(4'h6, WR, 9'h030, 2'b00);
        nv_busy = 1'b0;
        clr();
        `CHK("error_end", 1'b0, cmd_error)
        summarize();
    end
    initial begin
        idle(20000);
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
